// *** core/sas_pkg.sv ***
package sas_pkg;
   // Register map, one byte per address
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_CLKCFG = 4'h1;
   localparam logic [3:0] ADDR_PIN_ANALOG = 4'h2;
   localparam logic [3:0] ADDR_RES_CTRL = 4'h3;
   localparam logic [3:0] ADDR_VREF = 4'h4;
   localparam logic [3:0] ADDR_DATA_HI = 4'h5;
   localparam logic [3:0] ADDR_DATA_LO = 4'h6;
   localparam logic [3:0] ADDR_IRQ_FLAG = 4'h7;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h8;

   // Mode register fields
   localparam int MODE_POWER_BIT = 7;
   localparam int MODE_START_BIT = 6;
   localparam int MODE_DONE_BIT = 5;
   localparam int MODE_GATE_BIT = 4;
   localparam int MODE_CHAN_LSB = 0;

   // Clock configuration fields
   localparam int CLK_DIV_LSB = 2;
   localparam int CLK_SAMPLE_LSB = 0;

   // Resolution control fields
   localparam int RES_PB_LSB = 4;
   localparam int RES_SEL_LSB = 0;

   // Reference selection fields
   localparam int VREF_EXT_BIT = 4;
   localparam int VREF_LVL_LSB = 0;

   // Interrupt enable and flag fields
   localparam int IE_CONV_BIT = 0;
   localparam int IE_GLOBAL_BIT = 1;
   localparam int IF_CONV_BIT = 0;

   // Channel select codes
   localparam logic [3:0] CHAN_QUARTER_SUPPLY = 4'hb;

   // Conversion clock divider codes and ratios
   localparam logic [1:0] DIV_CODE_16 = 2'h0;
   localparam logic [1:0] DIV_CODE_8 = 2'h1;
   localparam logic [1:0] DIV_CODE_1 = 2'h2;
   localparam logic [1:0] DIV_CODE_2 = 2'h3;
   localparam logic [3:0] DIV_LIMIT_16 = 4'hf;
   localparam logic [3:0] DIV_LIMIT_8 = 4'h7;
   localparam logic [3:0] DIV_LIMIT_2 = 4'h1;
   localparam logic [3:0] DIV_LIMIT_1 = 4'h0;

   // Resolution codes and bit counts
   localparam logic [1:0] RES_CODE_8 = 2'h0;
   localparam logic [1:0] RES_CODE_10 = 2'h1;
   localparam logic [3:0] BITS_8 = 4'h8;
   localparam logic [3:0] BITS_10 = 4'ha;
   localparam logic [3:0] BITS_12 = 4'hc;
   localparam int RESULT_W = 12;
   localparam logic [3:0] RESULT_MSB = 4'hb;

   // Tail of every conversion, in conversion clock periods
   localparam logic [1:0] TAIL_PERIODS = 2'h2;

   // Engine states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_CONV = 4'b0100,
      ST_TAIL = 4'b1000
   } sas_state_t;

   function automatic logic [3:0] sas_bit_count(input logic [1:0] res);
      case (res)
         RES_CODE_8: sas_bit_count = BITS_8;
         RES_CODE_10: sas_bit_count = BITS_10;
         default: sas_bit_count = BITS_12;
      endcase
   endfunction

   function automatic logic [3:0] sas_sample_periods(input logic [1:0] sel);
      sas_sample_periods = 4'h1 << sel;
   endfunction
endpackage

// *** core/sas_clk_div.sv ***
module sas_clk_div
   import sas_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Control
   input wire logic i_run,
   input wire logic [1:0] i_div_sel,
   // Conversion clock enable
   output logic o_tick
);
   import sas_pkg::*;

   typedef struct packed {
      logic [3:0] count;
      logic tick;
   } sas_div_t;

   sas_div_t state;
   sas_div_t next_state;
   logic [3:0] limit;

   always_comb begin
      case (i_div_sel)
         DIV_CODE_16: limit = DIV_LIMIT_16;
         DIV_CODE_8: limit = DIV_LIMIT_8;
         DIV_CODE_1: limit = DIV_LIMIT_1;
         default: limit = DIV_LIMIT_2;
      endcase
      next_state = state;
      next_state.tick = 1'b0;
      if (!i_run) begin
         next_state.count = 4'h0;
      end else if (state.count >= limit) begin
         // One pulse per divided period of the instruction clock
         next_state.count = 4'h0;
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + 4'h1;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign o_tick = state.tick;
endmodule

// *** core/sas_sar_engine.sv ***
module sas_sar_engine
   import sas_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Control
   input wire logic i_tick,
   input wire logic i_start,
   input wire logic [1:0] i_sample_sel,
   input wire logic [1:0] i_res_sel,
   input wire logic i_cmp_high,
   // Status and result
   output logic o_busy,
   output logic o_done,
   output logic o_sample,
   output logic [sas_pkg::RESULT_W-1:0] o_trial
);
   import sas_pkg::*;

   typedef struct packed {
      sas_state_t st;
      logic [3:0] count;
      logic [3:0] bitpos;
      logic [3:0] lsb;
      logic [3:0] periods;
      logic [RESULT_W-1:0] value;
      logic done;
   } sas_eng_t;

   sas_eng_t state;
   sas_eng_t next_state;

   always_comb begin
      next_state = state;
      next_state.done = 1'b0;
      case (state.st)
         ST_IDLE: begin
            if (i_start) begin
               // Sample width and resolution are frozen for the whole conversion
               next_state.st = ST_SAMPLE;
               next_state.count = 4'h0;
               next_state.periods = sas_sample_periods(i_sample_sel);
               next_state.lsb = RESULT_MSB + 4'h1 - sas_bit_count(i_res_sel);
               next_state.value = '0;
            end
         end
         ST_SAMPLE: begin
            if (i_tick) begin
               if (state.count + 4'h1 >= state.periods) begin
                  next_state.st = ST_CONV;
                  next_state.bitpos = RESULT_MSB;
                  next_state.value[RESULT_MSB] = 1'b1;
               end else begin
                  next_state.count = state.count + 4'h1;
               end
            end
         end
         ST_CONV: begin
            // One bit decided per conversion clock period
            if (i_tick) begin
               if (!i_cmp_high) begin
                  next_state.value[state.bitpos] = 1'b0;
               end
               if (state.bitpos == state.lsb) begin
                  next_state.st = ST_TAIL;
                  next_state.count = 4'h0;
               end else begin
                  next_state.bitpos = state.bitpos - 4'h1;
                  next_state.value[state.bitpos - 4'h1] = 1'b1;
               end
            end
         end
         ST_TAIL: begin
            // Sample + bits + two periods in total
            if (i_tick) begin
               if (state.count + 4'h1 >= {2'h0, TAIL_PERIODS}) begin
                  next_state.st = ST_IDLE;
                  next_state.done = 1'b1;
               end else begin
                  next_state.count = state.count + 4'h1;
               end
            end
         end
         default: begin
            next_state.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= '{st: ST_IDLE, default: '0};
      end else begin
         state <= next_state;
      end
   end

   // Unresolved low bits were never set, so they stay zero
   assign o_trial = state.value;
   assign o_busy = (state.st != ST_IDLE);
   assign o_sample = (state.st == ST_SAMPLE);
   assign o_done = state.done;
endmodule

// *** core/sas_sar_adc_sequencer.sv ***
// Operation
// - Gate bit low routes no source and blocks conversions.
// - Codes 0-4 port A, 5-10 port B, 11 quarter supply, 12-15 nothing.
// - Pin config bits 0-7 cover PA0-4 and PB0-2; control bits 4-6 PB3-5.
// - A set pin config bit makes the pin analog-only, digital input off.
// - Conversion clock divides instruction clock by 16, 8, 1 or 2.
// - Sample width is 1, 2, 4 or 8 conversion clock periods.
// - Resolution field picks 8, 10 or 12 conversion bits.
// - Each approximation step takes one conversion clock period.
// - Conversion lasts sample width plus bit count plus two periods.
// - Writing start begins conversion; done reads 0 until it ends.
// - End of conversion sets the flag until firmware writes zero.
// - Flag reads as set only while its enable bit is one.
// - Both enables set: interrupt on done rising edge.
// - Result is at most twelve bits wide.
//
// The plain strobed port and the register offsets were left to the implementer.
module sas_sar_adc_sequencer
   import sas_pkg::*;
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Analog front end
   input wire logic i_cmp_high,
   output logic [3:0] o_source_sel,
   output logic o_source_en,
   output logic [10:0] o_pin_analog,
   output logic o_bias_en,
   output logic [2:0] o_upper_ref_sel,
   output logic o_sample_pulse,
   output logic [sas_pkg::RESULT_W-1:0] o_trial,
   // Interrupt
   output logic o_irq
);
   import sas_pkg::*;

   typedef struct packed {
      logic converter_power_enable;
      logic start;
      logic global_channel_gate;
      logic [3:0] channel_select;
      logic [1:0] conversion_clock_div;
      logic [1:0] sample_width_sel;
      logic [7:0] pin_analog_config;
      logic [2:0] pb_analog;
      logic [1:0] resolution;
      logic [4:0] upper_reference_sel;
      logic [RESULT_W-1:0] result;
      logic conv_flag;
      logic conversion_irq_enable;
      logic global_irq_enable;
      logic start_pulse;
      logic [7:0] rdata;
      logic [3:0] source_sel;
      logic source_en;
      logic [10:0] pin_analog;
      logic bias_en;
      logic [2:0] ref_sel;
      logic irq;
   } sas_top_t;

   sas_top_t state;
   sas_top_t next_state;

   logic tick;
   logic busy;
   logic done;
   logic sample;
   logic [RESULT_W-1:0] trial;
   logic [7:0] readback;

   sas_clk_div u_div (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      // Keep ticking while busy so a conversion caught by power off still finishes
      .i_run(state.converter_power_enable || busy),
      .i_div_sel(state.conversion_clock_div),
      .o_tick(tick)
   );

   sas_sar_engine u_eng (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_tick(tick),
      .i_start(state.start_pulse),
      .i_sample_sel(state.sample_width_sel),
      .i_res_sel(state.resolution),
      .i_cmp_high(i_cmp_high),
      .o_busy(busy),
      .o_done(done),
      .o_sample(sample),
      .o_trial(trial)
   );

   // Register readback; unmapped addresses read zero
   always_comb begin
      readback = 8'h00;
      case (i_addr)
         ADDR_MODE: begin
            readback[MODE_POWER_BIT] = state.converter_power_enable;
            readback[MODE_START_BIT] = state.start;
            // Done stays low while a conversion is pending
            readback[MODE_DONE_BIT] = !state.start && !busy;
            readback[MODE_GATE_BIT] = state.global_channel_gate;
            readback[MODE_CHAN_LSB +: 4] = state.channel_select;
         end
         ADDR_CLKCFG: begin
            readback[CLK_DIV_LSB +: 2] = state.conversion_clock_div;
            readback[CLK_SAMPLE_LSB +: 2] = state.sample_width_sel;
         end
         ADDR_PIN_ANALOG: begin
            readback = state.pin_analog_config;
         end
         ADDR_RES_CTRL: begin
            readback[RES_PB_LSB +: 3] = state.pb_analog;
            readback[RES_SEL_LSB +: 2] = state.resolution;
         end
         ADDR_VREF: begin
            readback[VREF_LVL_LSB +: 5] = state.upper_reference_sel;
         end
         ADDR_DATA_HI: begin
            readback = state.result[RESULT_W-1 -: 8];
         end
         ADDR_DATA_LO: begin
            readback[3:0] = state.result[3:0];
         end
         ADDR_IRQ_FLAG: begin
            // Flag is hidden while its enable is off
            readback[IF_CONV_BIT] = state.conv_flag && state.conversion_irq_enable;
         end
         ADDR_IRQ_EN: begin
            readback[IE_CONV_BIT] = state.conversion_irq_enable;
            readback[IE_GLOBAL_BIT] = state.global_irq_enable;
         end
         default: begin
            readback = 8'h00;
         end
      endcase
   end

   always_comb begin
      next_state = state;
      next_state.start_pulse = 1'b0;
      next_state.rdata = i_rd ? readback : 8'h00;

      if (i_wr) begin
         case (i_addr)
            ADDR_MODE: begin
               next_state.converter_power_enable = i_wdata[MODE_POWER_BIT];
               next_state.global_channel_gate = i_wdata[MODE_GATE_BIT];
               next_state.channel_select = i_wdata[MODE_CHAN_LSB +: 4];
               // Start only with power on, gate open and engine idle
               if (i_wdata[MODE_START_BIT] && i_wdata[MODE_POWER_BIT]
                   && i_wdata[MODE_GATE_BIT] && !state.start && !busy) begin
                  next_state.start = 1'b1;
                  next_state.start_pulse = 1'b1;
               end
            end
            ADDR_CLKCFG: begin
               next_state.conversion_clock_div = i_wdata[CLK_DIV_LSB +: 2];
               next_state.sample_width_sel = i_wdata[CLK_SAMPLE_LSB +: 2];
            end
            ADDR_PIN_ANALOG: begin
               next_state.pin_analog_config = i_wdata;
            end
            ADDR_RES_CTRL: begin
               next_state.pb_analog = i_wdata[RES_PB_LSB +: 3];
               next_state.resolution = i_wdata[RES_SEL_LSB +: 2];
            end
            ADDR_VREF: begin
               next_state.upper_reference_sel = i_wdata[VREF_LVL_LSB +: 5];
            end
            ADDR_IRQ_FLAG: begin
               // Only an explicit zero clears the flag
               if (!i_wdata[IF_CONV_BIT]) begin
                  next_state.conv_flag = 1'b0;
               end
            end
            ADDR_IRQ_EN: begin
               next_state.conversion_irq_enable = i_wdata[IE_CONV_BIT];
               next_state.global_irq_enable = i_wdata[IE_GLOBAL_BIT];
            end
            default: begin
            end
         endcase
      end

      // Completion wins over a clear in the same cycle
      if (done) begin
         next_state.conv_flag = 1'b1;
         next_state.start = 1'b0;
         next_state.result = trial;
      end
      // Power off abandons nothing in the engine; start is dropped once the engine is idle
      if (!next_state.converter_power_enable && !busy) begin
         next_state.start = 1'b0;
      end

      // Source routing: nothing reaches the converter with the gate closed
      next_state.source_sel = state.channel_select;
      next_state.source_en = state.global_channel_gate
                             && (state.channel_select <= CHAN_QUARTER_SUPPLY);
      // Digital input paths disabled on analog-only pins
      next_state.pin_analog = {state.pb_analog, state.pin_analog_config};
      next_state.bias_en = state.converter_power_enable;
      next_state.ref_sel = {state.upper_reference_sel[VREF_EXT_BIT],
                            state.upper_reference_sel[VREF_LVL_LSB +: 2]};
      // Flag is set on the done rising edge, so the level follows it
      next_state.irq = state.conv_flag && state.conversion_irq_enable
                       && state.global_irq_enable;
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Result width is capped at twelve bits
   assign o_trial = trial;
   assign o_sample_pulse = sample;
   assign o_rdata = state.rdata;
   assign o_source_sel = state.source_sel;
   assign o_source_en = state.source_en;
   assign o_pin_analog = state.pin_analog;
   assign o_bias_en = state.bias_en;
   assign o_upper_ref_sel = state.ref_sel;
   assign o_irq = state.irq;
endmodule

// *** dv/sas_chk.sv ***
module sas_chk
   import sas_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic [3:0] o_source_sel,
   input wire logic o_source_en,
   input wire logic [10:0] o_pin_analog,
   input wire logic o_sample_pulse,
   input wire logic o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic start_wr;
   logic [1:0] ie;
   logic [3:0] sw_hist;
   assign start_wr = i_wr && i_addr == ADDR_MODE && i_wdata[MODE_START_BIT]
      && i_wdata[MODE_POWER_BIT] && i_wdata[MODE_GATE_BIT];
   // Shadow of the enable register, updated on the same edge as the design's copy
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ie <= 2'h0;
         sw_hist <= 4'h0;
      end else begin
         if (i_wr && i_addr == ADDR_IRQ_EN) begin
            ie <= i_wdata[1:0];
         end
         sw_hist <= {sw_hist[2:0], start_wr};
      end
   end
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   // A write followed by a quiet cycle, so the config output has settled after it
   sequence s_wr_settle(hit);
      hit ##1 !i_wr;
   endsequence
   a_gate_off: assert property (
      s_wr_settle(i_wr && i_addr == ADDR_MODE && !i_wdata[MODE_GATE_BIT]) |-> ##1 !o_source_en)
      else $error("source routed with gate low");
   a_code_range: assert property (o_source_en |-> o_source_sel <= CHAN_QUARTER_SUPPLY)
      else $error("source enabled for unused code");
   a_pin_map: assert property (
      s_wr_settle(i_wr && i_addr == ADDR_PIN_ANALOG)
      |-> ##1 o_pin_analog[7:0] == $past(i_wdata, 2))
      else $error("pin config low byte mismatch");
   a_pb_map: assert property (
      s_wr_settle(i_wr && i_addr == ADDR_RES_CTRL)
      |-> ##1 o_pin_analog[10:8] == $past(i_wdata[6:4], 2))
      else $error("port B upper pin config mismatch");
   a_start_cause: assert property ($rose(o_sample_pulse) |-> sw_hist != 4'h0)
      else $error("sampling without a start write");
   a_sample_len: assert property ($rose(o_sample_pulse) |-> ##[1:130] !o_sample_pulse)
      else $error("sampling pulse too long");
   a_irq_enables: assert property (o_irq |-> $past(ie) == 2'h3)
      else $error("interrupt without both enables");
   a_flag_masked: assert property (
      i_rd && i_addr == ADDR_IRQ_FLAG && !ie[IE_CONV_BIT] |=> o_rdata[IF_CONV_BIT] == 1'b0)
      else $error("flag readable while disabled");
endmodule

bind sas_sar_adc_sequencer sas_chk u_chk (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_source_sel(o_source_sel),
   .o_source_en(o_source_en), .o_pin_analog(o_pin_analog),
   .o_sample_pulse(o_sample_pulse), .o_irq(o_irq)
);

// *** dv/sas_analog_model.sv ***
module sas_analog_model
   import sas_pkg::*;
(
   input wire logic [3:0] i_source_sel,
   input wire logic i_source_en,
   input wire logic [11:0] i_trial,
   input wire logic [11:0][11:0] i_level,
   output logic o_cmp_high
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pins are inputs with pulls off, so each carries its level undisturbed
   always_comb begin
      if (i_source_en && i_source_sel <= CHAN_QUARTER_SUPPLY) begin
         o_cmp_high = i_level[i_source_sel] >= i_trial;
      end else begin
         o_cmp_high = 1'b0;
      end
   end
endmodule

// *** dv/sar_adc_sequencer_tb_top.sv ***
module sar_adc_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sas_pkg::*;
   logic i_clock;
   logic i_rst_n;
   logic [3:0] i_addr;
   logic [7:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic i_cmp_high;
   logic [7:0] o_rdata;
   logic [3:0] o_source_sel;
   logic o_source_en;
   logic [10:0] o_pin_analog;
   logic o_bias_en;
   logic [2:0] o_upper_ref_sel;
   logic o_sample_pulse;
   logic [11:0] o_trial;
   logic o_irq;
   logic [11:0][11:0] level;
   logic [7:0] d;
   int n_errors = 0;
   int total_checks = 0;
   int seed = 32'h0ba342fa;
   int cycles = 0;
   int hi_cnt = 0;
   int smp_len = 0;

   sas_sar_adc_sequencer uut (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_high(i_cmp_high),
      .o_source_sel(o_source_sel), .o_source_en(o_source_en), .o_pin_analog(o_pin_analog),
      .o_bias_en(o_bias_en), .o_upper_ref_sel(o_upper_ref_sel),
      .o_sample_pulse(o_sample_pulse), .o_trial(o_trial), .o_irq(o_irq)
   );
   sas_analog_model u_analog (
      .i_source_sel(o_source_sel), .i_source_en(o_source_en), .i_trial(o_trial),
      .i_level(level), .o_cmp_high(i_cmp_high)
   );

   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end

   // Cycle count bounds the run and times each conversion
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         complete_run();
      end
   end

   always @(posedge i_clock) begin
      if (o_sample_pulse === 1'b1) begin
         hi_cnt <= hi_cnt + 1;
      end else if (hi_cnt != 0) begin
         smp_len <= hi_cnt;
         hi_cnt <= 0;
      end
   end

   task automatic complete_run();
      if (n_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
      total_checks++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      @(negedge i_clock);
      chk(nm, {4'h0, e}, {4'h0, o_rdata});
   endtask

   task automatic convert(input int ch, input int dv, input int sw, input int rs);
      int n;
      int s;
      int b;
      int r;
      int t;
      n = (dv == 0) ? 16 : (dv == 1) ? 8 : (dv == 2) ? 1 : 2;
      s = 1 << sw;
      b = (rs == 0) ? 8 : (rs == 1) ? 10 : 12;
      r = (level[ch] >> (12 - b)) << (12 - b);
      wr(ADDR_CLKCFG, 8'((dv << CLK_DIV_LSB) | sw));
      wr(ADDR_RES_CTRL, 8'h70 | 8'(rs));
      wr(ADDR_MODE, 8'hd0 | 8'(ch));
      t = cycles;
      rchk("mode busy", ADDR_MODE, 8'hd0 | 8'(ch));
      for (int k = 0; k < 800 && o_irq !== 1'b1; k++) @(posedge i_clock);
      chk_rng("conv cycles", (s + b + 1) * n, (s + b + 3) * n + 6, cycles - t);
      chk_rng("sample cycles", (s - 1) * n + 1, s * n + 1, smp_len);
      rchk("data hi", ADDR_DATA_HI, 8'(r >> 4));
      rchk("data lo", ADDR_DATA_LO, 8'(r & 15));
      rchk("mode done", ADDR_MODE, 8'hb0 | 8'(ch));
      rchk("flag set", ADDR_IRQ_FLAG, 8'h01);
      wr(ADDR_IRQ_EN, 8'h00);
      rchk("flag masked", ADDR_IRQ_FLAG, 8'h00);
      wr(ADDR_IRQ_EN, 8'h01);
      rchk("flag kept", ADDR_IRQ_FLAG, 8'h01);
      chk("irq no global", 12'h0, {11'h0, o_irq});
      wr(ADDR_IRQ_EN, 8'h03);
      wr(ADDR_IRQ_FLAG, 8'h00);
      rchk("flag clear", ADDR_IRQ_FLAG, 8'h00);
      chk("irq clear", 12'h0, {11'h0, o_irq});
   endtask

   initial begin
      i_rst_n = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 4'h0;
      i_wdata = 8'h00;
      for (int c = 0; c < 12; c++) level[c] = 12'($random(seed));
      level[0] = 12'hfff;
      level[1] = 12'h000;
      repeat (20) @(posedge i_clock);
      i_rst_n <= 1'b1;
      rchk("mode reset", ADDR_MODE, 8'h20);
      rchk("unmapped", 4'h9, 8'h00);
      for (int k = 0; k < 4; k++) begin
         d = 8'($random(seed));
         wr(ADDR_PIN_ANALOG, d);
         wr(ADDR_RES_CTRL, d & 8'h70);
         repeat (2) @(negedge i_clock);
         chk("pin analog", {1'b0, d[6:4], d}, {1'b0, o_pin_analog});
      end
      wr(ADDR_PIN_ANALOG, 8'hff);
      wr(ADDR_VREF, 8'h13);
      repeat (2) @(negedge i_clock);
      chk("upper ref", 12'h7, {9'h0, o_upper_ref_sel});
      wr(ADDR_IRQ_EN, 8'h03);
      for (int c = 0; c < 16; c++) begin
         wr(ADDR_MODE, 8'h10 | 8'(c));
         repeat (2) @(negedge i_clock);
         chk("source en", {11'h0, c < 12}, {11'h0, o_source_en});
         chk("source sel", 12'(c), {8'h0, o_source_sel});
         chk("bias off", 12'h0, {11'h0, o_bias_en});
      end
      wr(ADDR_MODE, 8'h90);
      repeat (6400) @(posedge i_clock);
      chk("bias on", 12'h1, {11'h0, o_bias_en});
      wr(ADDR_MODE, 8'hc5);
      repeat (40) @(negedge i_clock);
      chk("gate off en", 12'h0, {11'h0, o_source_en});
      chk("gate off smp", 12'h0, {11'h0, o_sample_pulse});
      rchk("gate off mode", ADDR_MODE, 8'ha5);
      for (int i = 0; i < 16; i++) begin
         convert(i % 12, i % 4, (i / 4) % 4, (i + i / 4) % 4);
      end
      complete_run();
   end
endmodule
